// [hw/fcmac_ctrl.sv]
// Two per-framer control registers: CRC6 variant selects, channel monitor
// selectors and elastic store align commands, plus the two channel monitors.
// Assumes the pointer-separation flags come from the system clock domains and
// the channel streams are already on clk.
//
// Summary of operation
// - Transmit CRC6 generator uses Japanese variant when transmit variant bit is one.
// - Transmit bits 4..0 select the transmit channel copied into its monitor.
// - Receive CRC6 checker uses Japanese variant when receive variant bit is one.
// - Receive align rising edge forces half-frame separation if pointers are closer.
// - Transmit align rising edge forces half-frame separation if pointers are closer.
// - No align action when separation is already at least half a frame.
// - Only rising transitions of an align bit trigger; held ones do nothing.
// - Receive bits 4..0 select the receive channel copied into its monitor.
`timescale 1ns/1ps

module fcmac_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Processor port
  input wire fcmac_pkg::fcmac_bus_req_type busReq,
  output logic [7:0] rdData,
  // Channel streams
  input wire fcmac_pkg::fcmac_chan_type txChan,
  input wire fcmac_pkg::fcmac_chan_type rxChan,
  // Elastic store status, asynchronous: separation under half a frame
  input wire logic rxSepShort,
  input wire logic txSepShort,
  // Controls to the framer
  output logic txCrcJapanese,
  output logic rxCrcJapanese,
  output logic rxStoreAlignPulse,
  output logic txStoreAlignPulse,
  output logic [7:0] txChannelMonitorReg,
  output logic [7:0] rxChannelMonitorReg
);

  fcmac_pkg::fcmac_state_type st;
  fcmac_pkg::fcmac_state_type next_st;

  function automatic logic [4:0] chanSel(input logic [7:0] ctrl);
    chanSel = ctrl[fcmac_pkg::MONITOR_CHAN_MSB:fcmac_pkg::MONITOR_CHAN_LSB];
  endfunction

  function automatic logic hit(input fcmac_pkg::fcmac_bus_req_type req, input logic [7:0] addr);
    hit = req.addr == addr;
  endfunction

  logic rxAlignBit;
  logic txAlignBit;
  assign rxAlignBit = st.rxCtrl[fcmac_pkg::RX_STORE_ALIGN_CMD_BIT];
  assign txAlignBit = st.rxCtrl[fcmac_pkg::TX_STORE_ALIGN_CMD_BIT];

  always_comb begin
    next_st = st;
    // Writes store the whole byte; unassigned bits are kept as written
    // so software reads back exactly what it wrote; zeros there are its duty
    if (busReq.wrEn && hit(busReq, fcmac_pkg::TX_CRC_MONITOR_CONTROL_ADDR)) begin
      next_st.txCtrl = busReq.wrData;
    end
    if (busReq.wrEn && hit(busReq, fcmac_pkg::RX_CRC_ALIGN_MONITOR_CONTROL_ADDR)) begin
      next_st.rxCtrl = busReq.wrData;
    end
    if (busReq.rdEn) begin
      if (hit(busReq, fcmac_pkg::TX_CRC_MONITOR_CONTROL_ADDR)) begin
        next_st.rdData = st.txCtrl;
      end else if (hit(busReq, fcmac_pkg::RX_CRC_ALIGN_MONITOR_CONTROL_ADDR)) begin
        next_st.rdData = st.rxCtrl;
      end else begin
        next_st.rdData = fcmac_pkg::READ_UNMAPPED;
      end
    end
    // Three-stage synchronisers; the first stage feeds only the second
    // Waiting for stages two and three to agree keeps a flag caught mid-change out
    next_st.rxShortSync = {st.rxShortSync[1:0], rxSepShort};
    next_st.txShortSync = {st.txShortSync[1:0], txSepShort};
    if (st.rxShortSync[1] == st.rxShortSync[2]) begin
      next_st.rxShort = st.rxShortSync[2];
    end
    if (st.txShortSync[1] == st.txShortSync[2]) begin
      next_st.txShort = st.txShortSync[2];
    end
    // Edge detection against the registered copy of the align bits
    // The copies clear with the register, so reset release gives no false edge
    next_st.prevRxAlign = rxAlignBit;
    next_st.prevTxAlign = txAlignBit;
    next_st.rxAlignPulse = rxAlignBit && !st.prevRxAlign && st.rxShort;
    next_st.txAlignPulse = txAlignBit && !st.prevTxAlign && st.txShort;
    // Monitors copy the selected channel as it passes
    if (txChan.chanValid && txChan.chanNum == chanSel(st.txCtrl)) begin
      next_st.txMonitor = txChan.chanData;
    end
    if (rxChan.chanValid && rxChan.chanNum == chanSel(st.rxCtrl)) begin
      next_st.rxMonitor = rxChan.chanData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
      st.txCtrl <= fcmac_pkg::CONTROL_RESET;
      st.rxCtrl <= fcmac_pkg::CONTROL_RESET;
      st.rdData <= fcmac_pkg::READ_UNMAPPED;
      st.txMonitor <= fcmac_pkg::MONITOR_RESET;
      st.rxMonitor <= fcmac_pkg::MONITOR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdData = st.rdData;
  assign txCrcJapanese = st.txCtrl[fcmac_pkg::TX_CRC_VARIANT_SEL_BIT];
  assign rxCrcJapanese = st.rxCtrl[fcmac_pkg::RX_CRC_VARIANT_SEL_BIT];
  assign rxStoreAlignPulse = st.rxAlignPulse;
  assign txStoreAlignPulse = st.txAlignPulse;
  assign txChannelMonitorReg = st.txMonitor;
  assign rxChannelMonitorReg = st.rxMonitor;

  // Checks
  // Antecedents read the registered state, as the logic does, so edges line up
  tx_crc_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    busReq.wrEn && hit(busReq, fcmac_pkg::TX_CRC_MONITOR_CONTROL_ADDR)
    |=> txCrcJapanese == $past(busReq.wrData[fcmac_pkg::TX_CRC_VARIANT_SEL_BIT]))
    else $error("transmit CRC variant not taken from write");

  rx_crc_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    busReq.wrEn && hit(busReq, fcmac_pkg::RX_CRC_ALIGN_MONITOR_CONTROL_ADDR)
    |=> rxCrcJapanese == $past(busReq.wrData[fcmac_pkg::RX_CRC_VARIANT_SEL_BIT]))
    else $error("receive CRC variant not taken from write");

  tx_mon_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
    txChan.chanValid && txChan.chanNum == chanSel(st.txCtrl) |=> txChannelMonitorReg == $past(txChan.chanData))
    else $error("transmit monitor missed selected channel");

  rx_mon_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(rxChan.chanValid && rxChan.chanNum == chanSel(st.rxCtrl)) |=> $stable(rxChannelMonitorReg))
    else $error("receive monitor changed on unselected channel");

  rx_align_fire_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(rxAlignBit) && st.rxShort |=> rxStoreAlignPulse)
    else $error("receive align did not fire");

  tx_align_fire_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(txAlignBit) && st.txShort |=> txStoreAlignPulse)
    else $error("transmit align did not fire");

  align_wide_sep_a: assert property (@(posedge clk) disable iff (!reset_n)
    !st.rxShort |=> !rxStoreAlignPulse)
    else $error("receive align fired with wide separation");

  align_held_a: assert property (@(posedge clk) disable iff (!reset_n)
    txAlignBit [*2] |=> !txStoreAlignPulse)
    else $error("transmit align fired on held bit");

  align_single_a: assert property (@(posedge clk) disable iff (!reset_n)
    rxStoreAlignPulse |=> !rxStoreAlignPulse)
    else $error("receive align pulse longer than one cycle");

  // Register state only moves on a write to its own address
  tx_crc_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(busReq.wrEn && hit(busReq, fcmac_pkg::TX_CRC_MONITOR_CONTROL_ADDR)) |=> $stable(txCrcJapanese))
    else $error("transmit CRC variant changed without a write");

  rx_crc_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(busReq.wrEn && hit(busReq, fcmac_pkg::RX_CRC_ALIGN_MONITOR_CONTROL_ADDR)) |=> $stable(rxCrcJapanese))
    else $error("receive CRC variant changed without a write");

  // Read data is the register value of the request cycle and holds until the next read
  tx_read_back_a: assert property (@(posedge clk) disable iff (!reset_n)
    busReq.rdEn && hit(busReq, fcmac_pkg::TX_CRC_MONITOR_CONTROL_ADDR) |=> rdData == $past(st.txCtrl))
    else $error("transmit control read back wrong");

  rx_read_back_a: assert property (@(posedge clk) disable iff (!reset_n)
    busReq.rdEn && hit(busReq, fcmac_pkg::RX_CRC_ALIGN_MONITOR_CONTROL_ADDR) |=> rdData == $past(st.rxCtrl))
    else $error("receive control read back wrong");

  read_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !busReq.rdEn |=> $stable(rdData))
    else $error("read data changed without a read");

  rx_mon_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
    rxChan.chanValid && rxChan.chanNum == chanSel(st.rxCtrl) |=> rxChannelMonitorReg == $past(rxChan.chanData))
    else $error("receive monitor missed selected channel");

  tx_mon_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(txChan.chanValid && txChan.chanNum == chanSel(st.txCtrl)) |=> $stable(txChannelMonitorReg))
    else $error("transmit monitor changed on unselected channel");

  tx_wide_sep_a: assert property (@(posedge clk) disable iff (!reset_n)
    !st.txShort |=> !txStoreAlignPulse)
    else $error("transmit align fired with wide separation");

  rx_align_held_a: assert property (@(posedge clk) disable iff (!reset_n)
    rxAlignBit [*2] |=> !rxStoreAlignPulse)
    else $error("receive align fired on held bit");

  tx_align_single_a: assert property (@(posedge clk) disable iff (!reset_n)
    txStoreAlignPulse |=> !txStoreAlignPulse)
    else $error("transmit align pulse longer than one cycle");

  // A flag is only taken once stages two and three agree
  rx_sync_filter_a: assert property (@(posedge clk) disable iff (!reset_n)
    st.rxShortSync[1] != st.rxShortSync[2] |=> $stable(st.rxShort))
    else $error("receive short flag taken before stages agreed");

  tx_sync_filter_a: assert property (@(posedge clk) disable iff (!reset_n)
    st.txShortSync[1] != st.txShortSync[2] |=> $stable(st.txShort))
    else $error("transmit short flag taken before stages agreed");

  // Nothing but a qualified rising edge may start an align
  rx_edge_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    !($rose(rxAlignBit) && st.rxShort) |=> !rxStoreAlignPulse)
    else $error("receive align fired without a rising edge");

  tx_edge_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    !($rose(txAlignBit) && st.txShort) |=> !txStoreAlignPulse)
    else $error("transmit align fired without a rising edge");

  rx_align_cov: cover property (@(posedge clk) disable iff (!reset_n) rxStoreAlignPulse);
  tx_align_cov: cover property (@(posedge clk) disable iff (!reset_n) txStoreAlignPulse);
  rx_align_skip_cov: cover property (@(posedge clk) disable iff (!reset_n) $rose(rxAlignBit) && !st.rxShort);
  tx_align_skip_cov: cover property (@(posedge clk) disable iff (!reset_n) $rose(txAlignBit) && !st.txShort);
  mon_copy_cov: cover property (@(posedge clk) disable iff (!reset_n)
    rxChan.chanValid && rxChan.chanNum == chanSel(st.rxCtrl));

endmodule

// [hw/fcmac_pkg.sv]
// Package for the framer CRC, monitor and elastic store align control block.
// Assumes an 8-bit processor port with a byte address and single-cycle strobes.
package fcmac_pkg;

  // Register byte addresses on the processor port
  localparam logic [7:0] TX_CRC_MONITOR_CONTROL_ADDR = 8'h19;
  localparam logic [7:0] RX_CRC_ALIGN_MONITOR_CONTROL_ADDR = 8'h1E;

  // Field positions
  localparam int TX_CRC_VARIANT_SEL_BIT = 7;
  localparam int RX_CRC_VARIANT_SEL_BIT = 7;
  localparam int RX_STORE_ALIGN_CMD_BIT = 6;
  localparam int TX_STORE_ALIGN_CMD_BIT = 5;
  localparam int MONITOR_CHAN_MSB = 4;
  localparam int MONITOR_CHAN_LSB = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MONITOR_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Synchroniser depth for inputs from the system clock domains
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrEn;
    logic rdEn;
  } fcmac_bus_req_type;

  typedef struct packed {
    logic [4:0] chanNum;
    logic [7:0] chanData;
    logic chanValid;
  } fcmac_chan_type;

  typedef struct packed {
    logic [7:0] txCtrl;
    logic [7:0] rxCtrl;
    logic [7:0] rdData;
    logic prevRxAlign;
    logic prevTxAlign;
    logic [SYNC_STAGES-1:0] rxShortSync;
    logic [SYNC_STAGES-1:0] txShortSync;
    logic rxShort;
    logic txShort;
    logic rxAlignPulse;
    logic txAlignPulse;
    logic [7:0] txMonitor;
    logic [7:0] rxMonitor;
  } fcmac_state_type;

endpackage

// [dv/fcmac_ctrl_tb.sv]
// Self-checking bench for the CRC variant, channel monitor and align controls.
// Assumes the design's own assertions run alongside; inputs change on the falling edge.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module fcmac_ctrl_tb;
  logic clk = 1'b0;
  logic resetN;
  fcmac_pkg::fcmac_bus_req_type busReq;
  fcmac_pkg::fcmac_chan_type txChan;
  fcmac_pkg::fcmac_chan_type rxChan;
  logic rxSepShort;
  logic txSepShort;
  logic [7:0] rdData;
  logic txCrcJapanese;
  logic rxCrcJapanese;
  logic rxStoreAlignPulse;
  logic txStoreAlignPulse;
  logic [7:0] txChannelMonitorReg;
  logic [7:0] rxChannelMonitorReg;
  int errTotal = 0;
  int nCompared = 0;
  int rxPulses = 0;
  int txPulses = 0;

  fcmac_ctrl u_dut (.clk(clk), .reset_n(resetN), .busReq(busReq), .rdData(rdData), .txChan(txChan),
    .rxChan(rxChan), .rxSepShort(rxSepShort), .txSepShort(txSepShort), .txCrcJapanese(txCrcJapanese),
    .rxCrcJapanese(rxCrcJapanese), .rxStoreAlignPulse(rxStoreAlignPulse),
    .txStoreAlignPulse(txStoreAlignPulse), .txChannelMonitorReg(txChannelMonitorReg),
    .rxChannelMonitorReg(rxChannelMonitorReg));

  always #12.5 clk = ~clk;

  // Pulses stand one cycle; the falling edge sees each once, away from the launching edge
  always @(negedge clk) begin
    if (rxStoreAlignPulse === 1'b1) rxPulses++;
    if (txStoreAlignPulse === 1'b1) txPulses++;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    busReq = '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(negedge clk);
    busReq.wrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(negedge clk);
    busReq = '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
    @(negedge clk);
    busReq.rdEn = 1'b0;
    @(negedge clk);
    `CHK(nm, e, rdData)
  endtask

  task automatic chan(input logic isTx, input logic [4:0] num, input logic [7:0] d);
    @(negedge clk);
    if (isTx) txChan = '{chanNum: num, chanData: d, chanValid: 1'b1};
    else rxChan = '{chanNum: num, chanData: d, chanValid: 1'b1};
    @(negedge clk);
    txChan.chanValid = 1'b0;
    rxChan.chanValid = 1'b0;
    @(negedge clk);
  endtask

  // The short flags pass a synchroniser, so a settling span precedes every align
  // The counters have one writer; each align compares against a snapshot
  task automatic align(input logic [7:0] d, input int expRx, input int expTx);
    int rxBase;
    int txBase;
    repeat (6) @(negedge clk);
    rxBase = rxPulses;
    txBase = txPulses;
    wr(8'h1E, d);
    repeat (6) @(negedge clk);
    `CHK("rxPulses", expRx, rxPulses - rxBase)
    `CHK("txPulses", expTx, txPulses - txBase)
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #(25.0 * 5000);
    errTotal++;
    report_and_stop;
  end

  initial begin
    busReq = '0;
    txChan = '0;
    rxChan = '0;
    rxSepShort = 1'b0;
    txSepShort = 1'b0;
    resetN = 1'b0;
    repeat (12) @(negedge clk);
    resetN = 1'b1;
    rd(8'h19, 8'h00, "txReg");
    rd(8'h33, 8'h00, "unmapped");
    wr(8'h19, 8'h80);
    `CHK("txCrc", 1'b1, txCrcJapanese)
    `CHK("rxCrc", 1'b0, rxCrcJapanese)
    wr(8'h1E, 8'h80);
    `CHK("rxCrc", 1'b1, rxCrcJapanese)
    rd(8'h1E, 8'h80, "rxReg");
    wr(8'h19, 8'h1F);
    `CHK("txCrc", 1'b0, txCrcJapanese)
    chan(1'b1, 5'd31, 8'hA5);
    `CHK("txMon", 8'hA5, txChannelMonitorReg)
    chan(1'b1, 5'd15, 8'h5A);
    `CHK("txMon", 8'hA5, txChannelMonitorReg)
    wr(8'h1E, 8'h10);
    `CHK("rxCrc", 1'b0, rxCrcJapanese)
    chan(1'b0, 5'd16, 8'h3C);
    `CHK("rxMon", 8'h3C, rxChannelMonitorReg)
    chan(1'b0, 5'd0, 8'hC3);
    `CHK("rxMon", 8'h3C, rxChannelMonitorReg)
    wr(8'h1E, 8'h00);
    rxSepShort = 1'b1;
    align(8'h40, 1, 0);
    align(8'h40, 0, 0);
    wr(8'h1E, 8'h00);
    align(8'h40, 1, 0);
    rxSepShort = 1'b0;
    wr(8'h1E, 8'h00);
    align(8'h60, 0, 0);
    wr(8'h1E, 8'h00);
    txSepShort = 1'b1;
    align(8'h20, 0, 1);
    align(8'h20, 0, 0);
    rd(8'h1E, 8'h20, "rxReg");
    // Mid-run reset: registers and monitors return to zero
    resetN = 1'b0;
    repeat (2) @(negedge clk);
    resetN = 1'b1;
    rd(8'h1E, 8'h00, "rxRegRst");
    `CHK("txMonRst", 8'h00, txChannelMonitorReg)
    `CHK("rxMonRst", 8'h00, rxChannelMonitorReg)
    report_and_stop;
  end
endmodule
